// File: core/sacm_pkg.sv
// constants for the servo alarm latch and clear manager
// assumes alarm slots are raised by same-clock logic, one bit per code
package sacm_pkg;

    localparam int ALARM_COUNT = 37;

    // slot index of each alarm that has a clear path of its own
    localparam int IDX_UNDERVOLT = 2;
    localparam int IDX_ADJUST = 10;
    localparam int IDX_ESTOP = 11;
    localparam int IDX_REV_LIMIT = 12;
    localparam int IDX_FWD_LIMIT = 13;
    localparam int IDX_ENC_TEMP_WARN = 31;
    localparam int IDX_FW_UPGRADE = 34;

    // slots cleared by the alarm-reset input (limits and eeprom included)
    localparam logic [ALARM_COUNT-1:0] RESET_CLEAR_MASK = 37'h03481FF1F3;
    // slots cleared by a power cycle (undervoltage always included)
    localparam logic [ALARM_COUNT-1:0] POWER_CLEAR_MASK = 37'h0037E0020C;

    // displayed alarm code per slot, bcd digits
    localparam logic [15:0] ALARM_CODE [ALARM_COUNT] = '{
        16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006,
        16'h0007, 16'h0008, 16'h0009, 16'h0011, 16'h0012, 16'h0013,
        16'h0014, 16'h0015, 16'h0016, 16'h0017, 16'h0018, 16'h0019,
        16'h0020, 16'h0022, 16'h0023, 16'h0024, 16'h0025, 16'h0026,
        16'h0027, 16'h0028, 16'h0029, 16'h0030, 16'h0031, 16'h0035,
        16'h0048, 16'h0067, 16'h0083, 16'h0085, 16'h0099, 16'h0555,
        16'h0880
    };
    localparam logic [15:0] NO_ALARM_CODE = 16'h0000;

    // fault-recovery config bit that lets undervoltage clear by itself
    localparam int CFG_UV_AUTO_BIT = 2;

    // two-step unlock values written to the special-function parameter
    localparam logic [15:0] FW_UNLOCK_FIRST = 16'h001E;
    localparam logic [15:0] FW_UNLOCK_SECOND = 16'h001C;

    typedef enum logic [2:0] {
        SACM_FW_IDLE = 3'b001,
        SACM_FW_GOT_FIRST = 3'b010,
        SACM_FW_ARMED = 3'b100
    } sacm_fw_state_t;

endpackage

// File: core/sacm_alarm_clear.sv
// alarm latch and clear manager: holds each alarm until its own clear
// assumes raise pulses and status levels come from logic on clk_in;
// the two digital input pins are asynchronous and get synchronised here
//
// Summary of operation
// R01 - Alarm-reset input rising clears all reset-clearable alarms.
// R02 - Undervoltage holds until power cycle; config bit 2 enables auto clear.
// R03 - Magnetic, encoder, wiring, encoder-overtemp alarms clear only on power-up.
// R04 - Emergency-stop alarm clears by itself once emergency-stop input is off.
// R05 - Limit alarms clear on alarm-reset, servo off, or opposite motion.
// R06 - Adjustment alarm clears after connector removed and auto adjustment done.
// R07 - Eeprom alarm: host resets parameters; device clears it on alarm-reset.
// R08 - Encoder temperature warning clears when temperature returns to normal.
// R09 - Host writes 30 then 28; firmware alarm clears at next power-up.
// R10 - Processing-failure alarms have no clear path except full reset.
// R11 - Host writes zero regen capacity when no resistor is fitted.
// R12 - Host matches regen resistance and capacity to the fitted resistor.
// R13 - Each alarm latches until its own clear; other clears leave it.
`timescale 1ns/1ps

module sacm_alarm_clear #(
    parameter int ALARMS = sacm_pkg::ALARM_COUNT
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [ALARMS-1:0] alarm_raise_in,
    input wire logic alarm_reset_input_in,
    input wire logic emergency_stop_input_in,
    input wire logic power_cycle_in,
    input wire logic voltage_normal_in,
    input wire logic temp_normal_in,
    input wire logic servo_on_in,
    input wire logic motion_forward_in,
    input wire logic motion_reverse_in,
    input wire logic io_connector_removed_in,
    input wire logic auto_adjust_done_in,
    input wire logic [15:0] fault_recovery_config_in,
    input wire logic special_function_wr_in,
    input wire logic [15:0] special_function_param_in,
    output logic [ALARMS-1:0] alarm_active_out,
    output logic [15:0] alarm_code_out,
    output logic alarm_any_out,
    output logic fw_clear_armed_out
);

    logic arst_meta_r;
    logic arst_sync_r;
    logic arst_prev_r;
    logic estop_meta_r;
    logic estop_sync_r;
    logic [ALARMS-1:0] active_r;
    logic [ALARMS-1:0] active_nxt;
    logic [15:0] code_r;
    logic [15:0] code_nxt;
    logic any_r;

    // unlock sequence state, one-hot
    sacm_pkg::sacm_fw_state_t fw_state_r;
    sacm_pkg::sacm_fw_state_t fw_state_nxt;
    logic armed_r;

    // pins pass two flops; only the second is read
    // meta flops reset low: a pin already high at reset release
    // shows as a rising edge two cycles later, never earlier
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            arst_meta_r <= 1'b0;
            arst_sync_r <= 1'b0;
        end else begin
            arst_meta_r <= alarm_reset_input_in;
            arst_sync_r <= arst_meta_r;
        end
    end

    // edge history of the synchronised alarm-reset level
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            arst_prev_r <= 1'b0;
        end else begin
            arst_prev_r <= arst_sync_r;
        end
    end

    // estop reads as released right after reset; the alarm slot
    // is empty then, so the early release clears nothing
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            estop_meta_r <= 1'b0;
            estop_sync_r <= 1'b0;
        end else begin
            estop_meta_r <= emergency_stop_input_in;
            estop_sync_r <= estop_meta_r;
        end
    end

    // "turned on" is taken as the rising edge, so holding it on
    // does not keep swallowing alarms raised later
    wire arst_rise = arst_sync_r & ~arst_prev_r;
    // power_cycle_in is a drive re-power pulse, not sys_rst_in;
    // a full reset drops the unlock and every alarm anyway
    wire fw_armed = (fw_state_r == sacm_pkg::SACM_FW_ARMED);

    // clear sources, one mask each
    wire [ALARMS-1:0] clr_reset = arst_rise ?
        sacm_pkg::RESET_CLEAR_MASK : '0; // [R01] [R07]
    wire [ALARMS-1:0] clr_power = power_cycle_in ?
        sacm_pkg::POWER_CLEAR_MASK : '0; // [R02] [R03]
    // undervoltage auto clear is a level: while the bit is set and
    // the voltage is good, a new undervoltage raise lasts one cycle
    wire uv_auto = fault_recovery_config_in[sacm_pkg::CFG_UV_AUTO_BIT] &
        voltage_normal_in; // [R02]
    wire estop_off = ~estop_sync_r; // [R04]
    // limits: servo off clears both; motion away from the limit
    // that tripped clears that one only
    wire rev_limit_clr = ~servo_on_in | motion_forward_in; // [R05]
    wire fwd_limit_clr = ~servo_on_in | motion_reverse_in; // [R05]
    // adjustment clears on the done pulse while wiring is removed
    wire adjust_clr = io_connector_removed_in & auto_adjust_done_in; // [R06]
    wire temp_clr = temp_normal_in; // [R08]
    wire fw_clr = power_cycle_in & fw_armed; // [R09]

    // processing-failure slots appear in no clear term at all [R10]
    always_comb begin
        logic [ALARMS-1:0] clr;
        clr = clr_reset | clr_power;
        clr[sacm_pkg::IDX_UNDERVOLT] = clr[sacm_pkg::IDX_UNDERVOLT] | uv_auto;
        clr[sacm_pkg::IDX_ESTOP] = estop_off;
        clr[sacm_pkg::IDX_REV_LIMIT] = clr[sacm_pkg::IDX_REV_LIMIT] |
            rev_limit_clr;
        clr[sacm_pkg::IDX_FWD_LIMIT] = clr[sacm_pkg::IDX_FWD_LIMIT] |
            fwd_limit_clr;
        clr[sacm_pkg::IDX_ADJUST] = adjust_clr;
        clr[sacm_pkg::IDX_ENC_TEMP_WARN] = temp_clr;
        clr[sacm_pkg::IDX_FW_UPGRADE] = fw_clr;
        // per-slot clear only, and a raise in the same cycle wins [R13]
        active_nxt = (active_r & ~clr) | alarm_raise_in;
    end

    // unlock sequence; any other write restarts it, arming lasts
    // until the power cycle that uses it
    // a repeated first value keeps the first step, so a host that
    // retries its first write does not have to start over
    // an illegal state code falls back to idle, never to armed
    always_comb begin
        fw_state_nxt = fw_state_r;
        case (fw_state_r)
            sacm_pkg::SACM_FW_IDLE: begin
                if (special_function_wr_in &&
                        special_function_param_in ==
                        sacm_pkg::FW_UNLOCK_FIRST) begin
                    fw_state_nxt = sacm_pkg::SACM_FW_GOT_FIRST; // [R09]
                end
            end
            sacm_pkg::SACM_FW_GOT_FIRST: begin
                if (special_function_wr_in) begin
                    if (special_function_param_in ==
                            sacm_pkg::FW_UNLOCK_SECOND) begin
                        fw_state_nxt = sacm_pkg::SACM_FW_ARMED; // [R09]
                    end else if (special_function_param_in !=
                            sacm_pkg::FW_UNLOCK_FIRST) begin
                        fw_state_nxt = sacm_pkg::SACM_FW_IDLE;
                    end
                end
            end
            sacm_pkg::SACM_FW_ARMED: begin
                if (power_cycle_in) begin
                    fw_state_nxt = sacm_pkg::SACM_FW_IDLE;
                end
            end
            default: fw_state_nxt = sacm_pkg::SACM_FW_IDLE;
        endcase
    end

    // lowest slot wins the code display; the loop runs from the
    // top down so the last match, the lowest slot, is kept
    always_comb begin
        code_nxt = sacm_pkg::NO_ALARM_CODE;
        for (int i = ALARMS - 1; i >= 0; i--) begin
            if (active_nxt[i]) begin
                code_nxt = sacm_pkg::ALARM_CODE[i];
            end
        end
    end

    // alarm latches [R13]
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            active_r <= '0;
        end else begin
            active_r <= active_nxt;
        end
    end

    // code and any are built from the next value, so they
    // change in the same cycle as the alarm bits they summarise
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            code_r <= sacm_pkg::NO_ALARM_CODE;
        end else begin
            code_r <= code_nxt;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            any_r <= 1'b0;
        end else begin
            any_r <= |active_nxt;
        end
    end

    // unlock state and its armed flag; the flag has its own flop
    // so the output is not a decode of the state bits
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            fw_state_r <= sacm_pkg::SACM_FW_IDLE;
            armed_r <= 1'b0;
        end else begin
            fw_state_r <= fw_state_nxt;
            armed_r <= (fw_state_nxt == sacm_pkg::SACM_FW_ARMED);
        end
    end

    always_comb begin
        alarm_active_out = active_r;
        alarm_code_out = code_r;
        alarm_any_out = any_r;
        fw_clear_armed_out = armed_r;
    end

endmodule

// File: sim/sacm_host_model.sv
// host side: two-step special-function write on request
// assumes start_in is a one-cycle request on clk_in
`timescale 1ns/1ps
module sacm_host_model (
    input wire logic clk_in,
    input wire logic start_in,
    output logic wr_out,
    output logic [15:0] param_out
);
    // no regen resistor fitted, so capacity stays zero
    localparam logic [15:0] REGEN_CAP = 16'h0000;
    logic step_r = 1'b0;
    initial wr_out = 1'b0;
    initial param_out = 16'h0000;
    always @(posedge clk_in) begin
        step_r <= start_in;
        wr_out <= start_in | step_r;
        if (start_in)
            param_out <= sacm_pkg::FW_UNLOCK_FIRST;
        else if (step_r)
            param_out <= sacm_pkg::FW_UNLOCK_SECOND;
        else
            param_out <= ~param_out; // idle cycles invert the last value, so it is not held stale
    end
endmodule

// File: sim/sacm_alarm_clear_asserts.sv
// assertions for the alarm latch and clear manager
// assumes binding to sacm_alarm_clear on its one clock
`timescale 1ns/1ps
module sacm_alarm_clear_asserts #(parameter int ALARMS = 37) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [ALARMS-1:0] alarm_raise_in,
    input wire logic emergency_stop_input_in,
    input wire logic power_cycle_in,
    input wire logic voltage_normal_in,
    input wire logic servo_on_in,
    input wire logic [15:0] fault_recovery_config_in,
    input wire logic special_function_wr_in,
    input wire logic [15:0] special_function_param_in,
    input wire logic [ALARMS-1:0] alarm_active_out,
    input wire logic [15:0] alarm_code_out,
    input wire logic alarm_any_out,
    input wire logic fw_clear_armed_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    any_flag_a:
        assert property (alarm_any_out == |alarm_active_out)
        else $error("any flag wrong");
    idle_code_a:
        assert property (!alarm_any_out |-> alarm_code_out == 16'h0000)
        else $error("code not zero when idle");
    raise_latch_a:
        assert property (1'b1 |=> (alarm_active_out & $past(alarm_raise_in))
            == $past(alarm_raise_in)) else $error("raise not latched");
    fatal_hold_a:
        assert property (!$fell(alarm_active_out[35]))
        else $error("unrecoverable alarm cleared");
    power_only_a:
        assert property ($fell(alarm_active_out[3]) |-> $past(power_cycle_in))
        else $error("power-only alarm cleared early");
    unlock_arm_a:
        assert property ($rose(fw_clear_armed_out) |-> $past(
            special_function_wr_in && special_function_param_in == 16'h001C))
        else $error("armed without second write");
    estop_free_a:
        assert property (!emergency_stop_input_in [*4] ##1 !alarm_raise_in[11]
            |=> !alarm_active_out[11]) else $error("estop alarm kept");
    servo_off_a:
        assert property (!servo_on_in && !alarm_raise_in[12]
            |=> !alarm_active_out[12]) else $error("limit kept at servo off");
    uv_auto_a:
        assert property (fault_recovery_config_in[2] && voltage_normal_in &&
            !alarm_raise_in[2] |=> !alarm_active_out[2])
        else $error("undervoltage kept");
    cover property ($rose(fw_clear_armed_out));
    cover property ($fell(alarm_active_out[12]));
    cover property ($fell(alarm_active_out[0]));
endmodule
bind sacm_alarm_clear sacm_alarm_clear_asserts #(.ALARMS(ALARMS)) u_chk (
    .clk_in, .sys_rst_in, .alarm_raise_in, .emergency_stop_input_in,
    .power_cycle_in, .voltage_normal_in, .servo_on_in,
    .fault_recovery_config_in, .special_function_wr_in,
    .special_function_param_in, .alarm_active_out, .alarm_code_out,
    .alarm_any_out, .fw_clear_armed_out);

// File: sim/sacm_alarm_clear_tb.sv
// bench for the alarm clear manager: table of raise/clear rows
// assumes the design package is compiled first
`timescale 1ns/1ps
module sacm_alarm_clear_tb;
    logic clk_in = 1'b0, sys_rst_in = 1'b1, arst = 1'b0, estop = 1'b1;
    logic pcyc = 1'b0, vnorm = 1'b0, tnorm = 1'b0, servo = 1'b1, fwd = 1'b0;
    logic rev = 1'b0, rmv = 1'b0, adj = 1'b0, start = 1'b0, wr, any, armed;
    logic [36:0] raise = '0, act;
    logic [15:0] cfg = 16'h0000, prm, code;
    int failures = 0, tests_run = 0, cyc = 0;
    // slot, action (0 pin reset, 1 power, 2 servo off, 3 estop off), cleared
    int rows [12][3] = '{'{0, 0, 1}, '{33, 0, 1},
        '{3, 0, 0}, '{3, 1, 1}, '{21, 0, 0},
        '{15, 0, 1},
        '{12, 2, 1}, '{13, 0, 1},
        '{11, 3, 1},
        '{2, 0, 0},
        '{35, 0, 0}, '{36, 1, 0}};
    always #12.5 clk_in = ~clk_in;
    sacm_alarm_clear u_sacm_alarm_clear (.clk_in(clk_in),
        .sys_rst_in(sys_rst_in), .alarm_raise_in(raise),
        .alarm_reset_input_in(arst), .emergency_stop_input_in(estop),
        .power_cycle_in(pcyc), .voltage_normal_in(vnorm),
        .temp_normal_in(tnorm), .servo_on_in(servo),
        .motion_forward_in(fwd), .motion_reverse_in(rev),
        .io_connector_removed_in(rmv), .auto_adjust_done_in(adj),
        .fault_recovery_config_in(cfg), .special_function_wr_in(wr),
        .special_function_param_in(prm), .alarm_active_out(act),
        .alarm_code_out(code), .alarm_any_out(any),
        .fw_clear_armed_out(armed));
    sacm_host_model u_sacm_host_model (.clk_in(clk_in), .start_in(start),
        .wr_out(wr), .param_out(prm));
    task automatic finish_test();
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(logic [15:0] got, logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tk(int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic rz(int s);
        @(posedge clk_in);
        raise[s] <= 1'b1;
        tk(1);
        raise <= '0;
        @(negedge clk_in);
        chk({15'h0, act[s]}, 16'h0001);
        @(posedge clk_in);
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 4000) begin
            failures++;
            finish_test();
        end
    end
    initial begin
        tk(6);
        sys_rst_in <= 1'b0;
        @(negedge clk_in);
        chk(act[15:0] | act[31:16] | {11'h0, act[36:32]}, 16'h0);
        chk({14'h0, any, armed}, 16'h0);
        rz(9);
        chk(code, 16'h0011);
        rz(0);
        chk(code, 16'h0001);
        foreach (rows[i]) begin
            rz(rows[i][0]);
            case (rows[i][1])
                0: arst <= 1'b1;
                1: pcyc <= 1'b1;
                2: servo <= 1'b0;
                default: estop <= 1'b0;
            endcase
            tk(rows[i][1] == 0 ? 6 : rows[i][1] == 3 ? 5 : 1);
            {arst, pcyc, servo, estop} <= 4'b0011;
            tk(6);
            @(negedge clk_in);
            chk({15'h0, act[rows[i][0]]}, 16'(!rows[i][2]));
        end
        rz(2);
        {cfg, vnorm} <= {16'h0004, 1'b1};
        rz(12);
        {fwd, tnorm} <= 2'b11;
        rz(13);
        rev <= 1'b1;
        rz(31);
        rz(10);
        adj <= 1'b1;
        tk(1);
        adj <= 1'b0;
        @(negedge clk_in);
        chk({11'h0, act[2], act[12], act[13], act[31], act[10]},
            16'h0001);
        @(posedge clk_in);
        {rmv, adj} <= 2'b11;
        tk(1);
        adj <= 1'b0;
        rz(34);
        start <= 1'b1;
        tk(1);
        start <= 1'b0;
        tk(4);
        @(negedge clk_in);
        chk({14'h0, act[10], armed}, 16'h0001);
        @(posedge clk_in);
        pcyc <= 1'b1;
        tk(1);
        pcyc <= 1'b0;
        @(negedge clk_in);
        chk({14'h0, act[34], armed}, 16'h0000);
        finish_test();
    end
endmodule
